// File: hdl/ewp_top.sv
// eeprom write protection, write-enable latch and pause control
// Summary of operation
// - lock clear: status writable, gated only by idle, latch and frame
// - lock set, pin high: status write accepted
// - lock set, pin low: status write refused
// - lock mode entered in either order
// - pin high releases lock; only level bits apply
// - 32k variant ranges per level code
// - 64k variant ranges per level code
// - latch clear refuses all writes
// - pause tristates output, ignores input and clock
// - deselect during pause ends the operation
// - pause follows pin directly while clock low
// - pause changes at next clock fall if high
// - low supply aborts writes, clears latch
// - no write while select held high
// - only set-enable command sets the latch
// - writes into protected block never done
`timescale 1ns/1ps
module ewp_top
   import ewp_pkg::*;
#(
   parameter bit MEM_64K     = 1'b0,
   parameter int WRITE_COUNT = ewp_pkg::WRITE_CYCLES
) (
   // system clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      nrst_i,
   // pins, asynchronous to clk_i
   input  wire logic                      wp_n_i,
   input  wire logic                      supply_low_i,
   // link side, clocked by the serial clock
   input  wire logic                      sck_i,
   input  wire logic                      cs_n_i,
   input  wire logic                      hold_n_i,
   input  wire logic                      si_i,
   input  wire logic                      so_d_i,
   input  wire logic                      so_en_i,
   output logic                           si_o,
   output logic                           link_active_o,
   output logic                           so_o,
   output logic                           so_oe_o,
   // decoded commands from the instruction decoder
   input  wire logic                      set_write_enable_cmd_i,
   input  wire logic                      clear_write_enable_cmd_i,
   input  wire logic                      status_write_cmd_i,
   input  wire logic                      st_lock_i,
   input  wire logic                      st_hi_i,
   input  wire logic                      st_lo_i,
   input  wire logic                      array_write_cmd_i,
   input  wire logic [ewp_pkg::ADDR_W-1:0] array_addr_i,
   // status
   output logic                           write_enable_latch_o,
   output logic                           status_lock_bit_o,
   output logic                           protect_level_hi_o,
   output logic                           protect_level_lo_o,
   output logic                           hardware_lock_mode_o,
   output logic                           software_block_mode_o,
   output logic                           write_busy_o,
   // array write sequencing
   output logic                           array_wr_start_o,
   output logic [ewp_pkg::ADDR_W-1:0]     array_wr_addr_o,
   output logic                           write_abort_o,
   output logic                           cmd_refused_o,
   output logic                           op_abort_o
);
   localparam int CNT_W = $clog2(WRITE_COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_COUNT - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   // ****************************************
   // protected range decode
   // ****************************************
   function automatic logic prot_hit(input logic [ADDR_W-1:0] a,
                                     input logic [1:0]        lvl,
                                     input logic              big);
      logic [ADDR_W-1:0] base;
      logic [ADDR_W-1:0] top;
      logic [ADDR_W-1:0] aa;
      begin
         base = big ? BASE64_ALL : BASE32_ALL;
         top  = big ? TOP64 : TOP32;
         aa   = a & top;
         case (lvl)
            LVL_QTR:  base = big ? BASE64_QTR : BASE32_QTR;
            LVL_HALF: base = big ? BASE64_HALF : BASE32_HALF;
            LVL_ALL:  base = big ? BASE64_ALL : BASE32_ALL;
            default:  base = top;
         endcase
         prot_hit = (lvl != LVL_NONE) && (aa >= base);
      end
   endfunction : prot_hit

   // ****************************************
   // link domain: pause timing on the serial clock
   // ****************************************
   // frozen pause level, caught at each rising clock edge; while the
   // clock is high the pin is not looked at, so a change takes effect
   // only when the clock falls again
   logic pause_frozen_r;
   logic paused;

   always_ff @(posedge sck_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pause_frozen_r <= 1'b0;
      end
      else
      begin
         pause_frozen_r <= ~hold_n_i;
      end
   end

   // with the clock low the pin acts at once, no delay
   assign paused = sck_i ? pause_frozen_r : ~hold_n_i;

   // pause leaves the select alone; the host keeps it low meanwhile
   assign link_active_o = ~cs_n_i & ~paused;
   assign si_o          = si_i & link_active_o;
   assign so_o          = so_d_i;
   assign so_oe_o       = so_en_i & link_active_o;

   // ****************************************
   // crossing into the system clock domain
   // ****************************************
   logic [3:0] pin_s;
   logic       wp_n_s;
   logic       supply_low_s;
   logic       cs_n_s;
   logic       paused_s;

   ewp_sync #(
      .WIDTH (4),
      .INIT  (32'h7)
   ) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    ({paused, cs_n_i, supply_low_i, wp_n_i}),
      .q_o    (pin_s)
   );

   assign wp_n_s       = pin_s[0];
   assign supply_low_s = pin_s[1];
   assign cs_n_s       = pin_s[2];
   assign paused_s     = pin_s[3];

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      ewp_state_e        st;
      logic              write_enable_latch;
      logic              lock;
      logic [1:0]        lvl;
      logic              new_lock;
      logic [1:0]        new_lvl;
      logic [CNT_W-1:0]  cnt;
      logic              frame;
      logic              cs_n_d;
      logic [ADDR_W-1:0] addr;
      logic              start;
      logic              refused;
      logic              abort;
      logic              op_abort;
   } ewp_top_s;

   ewp_top_s s_r;
   ewp_top_s s_nxt;

   logic hw_lock;
   logic idle;
   logic st_ok;
   logic arr_prot;
   logic arr_ok;
   logic wr_req;

   // lock mode is pure combination of bit and pin: either order works,
   // and a high pin drops it once it has passed the two-flop synchroniser
   assign hw_lock  = s_r.lock & ~wp_n_s;
   assign idle     = (s_r.st == EWP_IDLE);
   assign arr_prot = prot_hit(array_addr_i, s_r.lvl, MEM_64K);
   // lock clear, or lock set with pin high: only idle, the latch and the frame matter
   assign st_ok    = idle & s_r.frame & s_r.write_enable_latch & ~hw_lock;
   assign arr_ok   = idle & s_r.frame & s_r.write_enable_latch & ~arr_prot;
   assign wr_req   = status_write_cmd_i | array_write_cmd_i;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.start    = 1'b0;
      s_nxt.refused  = 1'b0;
      s_nxt.abort    = 1'b0;
      s_nxt.op_abort = 1'b0;
      s_nxt.cs_n_d   = cs_n_s;
      if (!cs_n_s)
      begin
         s_nxt.frame = 1'b1;
      end
      // deselect while paused ends the current operation
      if (cs_n_s && !s_r.cs_n_d && paused_s)
      begin
         s_nxt.op_abort = 1'b1;
         s_nxt.frame    = 1'b0;
      end
      if (clear_write_enable_cmd_i)
      begin
         s_nxt.write_enable_latch = 1'b0;
      end
      case (s_r.st)
         EWP_IDLE:
         begin
            // a write needs a frame first; select held high gives none
            if (wr_req)
            begin
               s_nxt.frame = 1'b0;
            end
            if (status_write_cmd_i && st_ok)
            begin
               s_nxt.st       = EWP_ST_WR;
               s_nxt.cnt      = CNT_ZERO;
               s_nxt.new_lock = st_lock_i;
               s_nxt.new_lvl  = {st_hi_i, st_lo_i};
            end
            else if (array_write_cmd_i && !status_write_cmd_i && arr_ok)
            begin
               s_nxt.st    = EWP_ARR_WR;
               s_nxt.cnt   = CNT_ZERO;
               s_nxt.addr  = array_addr_i;
               s_nxt.start = 1'b1;
            end
            else if (wr_req)
            begin
               // refused: stored bits are left as they are
               s_nxt.refused = 1'b1;
            end
         end
         EWP_ST_WR, EWP_ARR_WR:
         begin
            if (wr_req)
            begin
               s_nxt.refused = 1'b1;
            end
            if (s_r.cnt == CNT_LAST)
            begin
               s_nxt.st  = EWP_IDLE;
               s_nxt.write_enable_latch = 1'b0;
               // old bits stay visible until the write completes
               if (s_r.st == EWP_ST_WR)
               begin
                  s_nxt.lock = s_r.new_lock;
                  s_nxt.lvl  = s_r.new_lvl;
               end
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
         end
         default:
         begin
            s_nxt.st = EWP_IDLE;
         end
      endcase
      // set wins over every clear except the supply monitor
      if (set_write_enable_cmd_i)
      begin
         s_nxt.write_enable_latch = 1'b1;
      end
      // low supply cancels any write in flight and drops the latch
      if (supply_low_s)
      begin
         s_nxt.st      = EWP_IDLE;
         s_nxt.write_enable_latch     = 1'b0;
         s_nxt.frame   = 1'b0;
         s_nxt.start   = 1'b0;
         s_nxt.refused = 1'b0;
         s_nxt.abort   = ~idle;
      end
   end

   // a power-on reset leaves the latch clear as well
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_r <= '{st: EWP_IDLE, cs_n_d: 1'b1, default: '0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign write_enable_latch_o  = s_r.write_enable_latch;
   assign status_lock_bit_o     = s_r.lock;
   assign protect_level_hi_o    = s_r.lvl[1];
   assign protect_level_lo_o    = s_r.lvl[0];
   assign hardware_lock_mode_o  = hw_lock;
   assign software_block_mode_o = ~hw_lock;
   assign write_busy_o          = ~idle;
   assign array_wr_start_o      = s_r.start;
   assign array_wr_addr_o       = s_r.addr;
   assign write_abort_o         = s_r.abort;
   assign cmd_refused_o         = s_r.refused;
   assign op_abort_o            = s_r.op_abort;

   // ****************************************
   // checks
   // ****************************************
   property p_supply_clears;
      @(posedge clk_i) disable iff (!nrst_i)
      supply_low_s |=> !s_r.write_enable_latch && idle;
   endproperty
   a_supply_clears: assert property (p_supply_clears)
      else $error("latch or write survived low supply");

   property p_lock_refuses;
      @(posedge clk_i) disable iff (!nrst_i)
      status_write_cmd_i && s_r.lock && !wp_n_s && !supply_low_s
         |=> s_r.st != EWP_ST_WR || $past(s_r.st) == EWP_ST_WR;
   endproperty
   a_lock_refuses: assert property (p_lock_refuses)
      else $error("status write taken in lock mode");

   property p_refused_stable;
      @(posedge clk_i) disable iff (!nrst_i)
      idle && status_write_cmd_i && !st_ok
         |=> $stable(s_r.lock) && $stable(s_r.lvl) && idle;
   endproperty
   a_refused_stable: assert property (p_refused_stable)
      else $error("refused status write changed bits");

   property p_prot_block;
      @(posedge clk_i) disable iff (!nrst_i)
      array_write_cmd_i && arr_prot |=> !array_wr_start_o;
   endproperty
   a_prot_block: assert property (p_prot_block)
      else $error("write started into protected block");

   property p_wel_source;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(s_r.write_enable_latch) |-> $past(set_write_enable_cmd_i);
   endproperty
   a_wel_source: assert property (p_wel_source)
      else $error("latch set without set-enable command");

   property p_unlocked_accept;
      @(posedge clk_i) disable iff (!nrst_i)
      idle && status_write_cmd_i && s_r.frame && s_r.write_enable_latch && !s_r.lock
         && !supply_low_s |=> s_r.st == EWP_ST_WR;
   endproperty
   a_unlocked_accept: assert property (p_unlocked_accept)
      else $error("status write refused with lock clear");

   property p_no_wel_no_write;
      @(posedge clk_i) disable iff (!nrst_i)
      idle && !s_r.write_enable_latch && wr_req |=> idle && !array_wr_start_o;
   endproperty
   a_no_wel_no_write: assert property (p_no_wel_no_write)
      else $error("write taken with latch clear");

   property p_pause_deselect;
      @(posedge clk_i) disable iff (!nrst_i)
      cs_n_s && !s_r.cs_n_d && paused_s |=> op_abort_o ##1 !op_abort_o;
   endproperty
   a_pause_deselect: assert property (p_pause_deselect)
      else $error("deselect in pause did not end operation");
endmodule : ewp_top

// File: hdl/ewp_pkg.sv
// constants for the eeprom write-protect and pause block
package ewp_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_TIME_NS = 5000000;
   localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
   // ****************************************
   // array geometry and protected bases
   // ****************************************
   localparam int          ADDR_W      = 13;
   localparam logic [12:0] BASE32_QTR  = 13'h0C00;
   localparam logic [12:0] BASE32_HALF = 13'h0800;
   localparam logic [12:0] BASE32_ALL  = 13'h0000;
   localparam logic [12:0] TOP32       = 13'h0FFF;
   localparam logic [12:0] BASE64_QTR  = 13'h1800;
   localparam logic [12:0] BASE64_HALF = 13'h1000;
   localparam logic [12:0] BASE64_ALL  = 13'h0000;
   localparam logic [12:0] TOP64       = 13'h1FFF;
   // ****************************************
   // protection level codes (hi, lo)
   // ****************************************
   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_QTR  = 2'h1;
   localparam logic [1:0] LVL_HALF = 2'h2;
   localparam logic [1:0] LVL_ALL  = 2'h3;
   // ****************************************
   // write sequencer states; idle to array write flips both bits
   // ****************************************
   typedef enum logic [1:0] {
      EWP_IDLE   = 2'h0,
      EWP_ST_WR  = 2'h1,
      EWP_ARR_WR = 2'h3
   } ewp_state_e;
endpackage : ewp_pkg

// File: hdl/ewp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ewp_sync #(
   parameter int          WIDTH = 1,
   parameter logic [31:0] INIT  = 32'h0
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // levels
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ewp_sync_s;

   ewp_sync_s s_r;
   ewp_sync_s s_nxt;

   // first stage is read by the second stage only
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.meta = d_i;
      s_nxt.sync = s_r.meta;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_r <= {INIT[WIDTH-1:0], INIT[WIDTH-1:0]};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.sync;
endmodule : ewp_sync

// File: verification/ewp_host.sv
// spi host model driving select, serial clock, pause and data
`timescale 1ns/1ps
module ewp_host (
   // pins toward the device
   output logic cs_n_o,
   output logic sck_o,
   output logic hold_n_o,
   output logic si_o
);
   // *****
   // idle: deselected, clock parked low
   // *****
   initial
   begin
      cs_n_o   = 1'b1;
      sck_o    = 1'b0;
      hold_n_o = 1'b1;
      si_o     = 1'b1;
   end

   // direct pin control for pause sequences
   task pins(input logic cs, input logic ck, input logic hd);
      cs_n_o   = cs;
      sck_o    = ck;
      hold_n_o = hd;
   endtask : pins

   // one byte at a 48 ns clock; clock stands still outside frames
   task frame(input logic [7:0] b);
      int i;
      cs_n_o = 1'b0;
      for (i = 7; i >= 0; i--)
      begin
         si_o = b[i];
         #24 sck_o = 1'b1;
         #24 sck_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      si_o = ~si_o;
   endtask : frame
endmodule : ewp_host

// File: verification/ewp_top_tb.sv
// self-checking bench for the write-protect and pause block
`timescale 1ns/1ps
module ewp_top_tb;
   import ewp_pkg::*;
   localparam int WC = 20;
   logic clk_i, nrst_i, wp_n_i, supply_low_i, so_d_i, so_en_i;
   logic sck_i, cs_n_i, hold_n_i, si_i, si_o, so_o, so_oe_o;
   logic set_write_enable_cmd_i, clear_write_enable_cmd_i;
   logic status_write_cmd_i, st_lock_i, st_hi_i, st_lo_i;
   logic array_write_cmd_i, link_active_o, write_enable_latch_o;
   logic [ADDR_W-1:0] array_addr_i, array_wr_addr_o;
   logic status_lock_bit_o, protect_level_hi_o, protect_level_lo_o;
   logic hardware_lock_mode_o, software_block_mode_o, write_busy_o;
   logic array_wr_start_o, write_abort_o, cmd_refused_o, op_abort_o;
   int miscompares = 0;
   int comparisons = 0;
   logic ok, abt, ok64, rf, busy64;
   // upper entries alias onto the lower ones in the small map
   logic [12:0] pa [9] = '{13'h0C00, 13'h0BFF, 13'h0800, 13'h07FF,
                           13'h0000, 13'h1800, 13'h17FF, 13'h1000,
                           13'h0FFF};

   ewp_top #(.MEM_64K(1'b0), .WRITE_COUNT(WC)) u_dut (.clk_i, .nrst_i,
      .wp_n_i, .supply_low_i, .sck_i, .cs_n_i, .hold_n_i, .si_i, .so_d_i,
      .so_en_i, .si_o, .link_active_o, .so_o, .so_oe_o,
      .set_write_enable_cmd_i, .clear_write_enable_cmd_i,
      .status_write_cmd_i, .st_lock_i, .st_hi_i, .st_lo_i,
      .array_write_cmd_i, .array_addr_i, .write_enable_latch_o,
      .status_lock_bit_o, .protect_level_hi_o, .protect_level_lo_o,
      .hardware_lock_mode_o, .software_block_mode_o, .write_busy_o,
      .array_wr_start_o, .array_wr_addr_o, .write_abort_o,
      .cmd_refused_o, .op_abort_o);
   // large map twin: same stimulus, only busy is watched
   ewp_top #(.MEM_64K(1'b1), .WRITE_COUNT(WC)) u_dut64 (.clk_i, .nrst_i,
      .wp_n_i, .supply_low_i, .sck_i, .cs_n_i, .hold_n_i, .si_i, .so_d_i,
      .so_en_i, .si_o(), .link_active_o(), .so_o(), .so_oe_o(),
      .set_write_enable_cmd_i, .clear_write_enable_cmd_i,
      .status_write_cmd_i, .st_lock_i, .st_hi_i, .st_lo_i,
      .array_write_cmd_i, .array_addr_i, .write_enable_latch_o(),
      .status_lock_bit_o(), .protect_level_hi_o(), .protect_level_lo_o(),
      .hardware_lock_mode_o(), .software_block_mode_o(),
      .write_busy_o(busy64), .array_wr_start_o(), .array_wr_addr_o(),
      .write_abort_o(), .cmd_refused_o(), .op_abort_o());
   ewp_host u_host (.cs_n_o(cs_n_i), .sck_o(sck_i), .hold_n_o(hold_n_i),
      .si_o(si_i));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // *****
   // helpers
   // *****
   task close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   task chk(input string nm, input logic [12:0] seen, input logic [12:0] ex);
      comparisons++;
      if (seen !== ex)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   function automatic logic prot(input logic [12:0] a, input int c,
                                 input logic big);
      if (big)
         return c == 3 || (c == 2 && a >= 13'h1000) ||
                (c == 1 && a >= 13'h1800);
      return c == 3 || (c == 2 && a[11:0] >= 12'h800) ||
             (c == 1 && a[11:0] >= 12'hC00);
   endfunction : prot

   // one write: optional latch set, optional frame, optional supply drop
   task do_wr(input logic st, input logic [2:0] sb, input logic [12:0] a,
              input logic we, input logic frm, input logic ab);
      int i;
      ok  = 1'b0;
      abt = 1'b0;
      ok64 = 1'b0;
      rf  = 1'b0;
      if (we)
      begin
         set_write_enable_cmd_i = 1'b1;
         tick(1);
         set_write_enable_cmd_i = 1'b0;
      end
      if (frm)
         u_host.frame(8'hA4);
      tick(3);
      status_write_cmd_i = st;
      array_write_cmd_i  = !st;
      {st_lock_i, st_hi_i, st_lo_i} = sb;
      array_addr_i = a;
      tick(1);
      status_write_cmd_i = 1'b0;
      array_write_cmd_i  = 1'b0;
      for (i = 0; i < 3; i++)
      begin
         if (write_busy_o === 1'b1)
            ok = 1'b1;
         if (busy64 === 1'b1)
            ok64 = 1'b1;
         if (cmd_refused_o === 1'b1)
            rf = 1'b1;
         if (array_wr_start_o === 1'b1)
            chk("wr addr", array_wr_addr_o, a);
         tick(1);
      end
      chk("refused", rf, !ok);
      for (i = 0; i < WC + 20; i++)
      begin
         if (write_abort_o === 1'b1)
            abt = 1'b1;
         if (ab && i == 5)
            supply_low_i = 1'b1;
         if (write_busy_o === 1'b0 && busy64 === 1'b0 &&
             i > (ab ? 15 : 4))
            break;
         tick(1);
      end
      if (write_busy_o !== 1'b0 || busy64 !== 1'b0)
      begin
         miscompares++;
         close_out;
      end
   endtask : do_wr

   // *****
   // main sequence
   // *****
   initial
   begin
      {nrst_i, supply_low_i, so_d_i, so_en_i, wp_n_i} = 5'h07;
      {set_write_enable_cmd_i, clear_write_enable_cmd_i} = 2'h0;
      {status_write_cmd_i, array_write_cmd_i} = 2'h0;
      {st_lock_i, st_hi_i, st_lo_i} = 3'h0;
      array_addr_i = 13'h0000;
      repeat (12) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      tick(4);
      chk("wel", write_enable_latch_o, 0);
      set_write_enable_cmd_i = 1'b1;
      tick(1);
      set_write_enable_cmd_i = 1'b0;
      tick(2);
      chk("wel", write_enable_latch_o, 1);
      clear_write_enable_cmd_i = 1'b1;
      tick(1);
      clear_write_enable_cmd_i = 1'b0;
      tick(2);
      chk("wel", write_enable_latch_o, 0);
      do_wr(0, 0, 13'h0100, 0, 1, 0);
      chk("no latch", ok, 0);
      do_wr(0, 0, 13'h0100, 1, 0, 0);
      chk("no frame", ok, 0);
      do_wr(0, 0, 13'h0100, 1, 1, 0);
      chk("plain", ok, 1);
      chk("wel", write_enable_latch_o, 0);
      for (int c = 0; c < 4; c++)
      begin
         do_wr(1, {1'b0, 2'(c)}, 0, 1, 1, 0);
         chk("st ok", ok, 1);
         chk("levels", {protect_level_hi_o, protect_level_lo_o}, c);
         for (int k = 0; k < 9; k++)
         begin
            do_wr(0, 0, pa[k], 1, 1, 0);
            chk("arr ok", ok, !prot(pa[k], c, 1'b0));
            chk("arr 64k", ok64, !prot(pa[k], c, 1'b1));
         end
      end
      do_wr(1, 3'h4, 0, 1, 1, 0);
      chk("lock set", ok, 1);
      wp_n_i = 1'b0;
      tick(4);
      chk("hw", hardware_lock_mode_o, 1);
      chk("sw", software_block_mode_o, 0);
      do_wr(1, 3'h3, 0, 1, 1, 0);
      chk("locked st", ok, 0);
      chk("bits", {status_lock_bit_o, protect_level_hi_o,
                   protect_level_lo_o}, 4);
      do_wr(0, 0, 13'h0000, 1, 1, 0);
      chk("hw arr", ok, 1);
      wp_n_i = 1'b1;
      tick(4);
      chk("hw", hardware_lock_mode_o, 0);
      do_wr(1, 3'h0, 0, 1, 1, 0);
      chk("st ok", ok, 1);
      wp_n_i = 1'b0;
      tick(4);
      do_wr(1, 3'h4, 0, 1, 1, 0);
      chk("pin first", ok, 1);
      chk("hw", hardware_lock_mode_o, 1);
      wp_n_i = 1'b1;
      tick(4);
      do_wr(1, 3'h0, 0, 1, 1, 0);
      do_wr(0, 0, 13'h0100, 1, 1, 1);
      chk("abort", abt, 1);
      chk("wel", write_enable_latch_o, 0);
      supply_low_i = 1'b0;
      tick(5);
      do_wr(0, 0, 13'h0100, 0, 1, 0);
      chk("no re-set", ok, 0);
      do_wr(0, 0, 13'h0100, 1, 1, 0);
      chk("re-set", ok, 1);
      // pause is combinational on the pins, so sample 1 ns later
      u_host.pins(0, 0, 1);
      #1 chk("oe", so_oe_o, 1);
      chk("si", si_o, 1);
      chk("so", so_o, 1);
      u_host.pins(0, 0, 0);
      #1 chk("oe", so_oe_o, 0);
      chk("active", link_active_o, 0);
      chk("si", si_o, 0);
      u_host.pins(0, 0, 1);
      #1 chk("oe", so_oe_o, 1);
      u_host.pins(0, 1, 1);
      #1 u_host.pins(0, 1, 0);
      #1 chk("oe", so_oe_o, 1);
      u_host.pins(0, 0, 0);
      #1 chk("oe", so_oe_o, 0);
      u_host.pins(0, 1, 0);
      #1 u_host.pins(0, 1, 1);
      #1 chk("oe", so_oe_o, 0);
      u_host.pins(0, 0, 1);
      #1 chk("oe", so_oe_o, 1);
      u_host.pins(0, 0, 0);
      tick(4);
      u_host.pins(1, 0, 0);
      abt = 1'b0;
      repeat (8)
      begin
         if (op_abort_o === 1'b1)
            abt = 1'b1;
         tick(1);
      end
      chk("op abort", abt, 1);
      u_host.pins(1, 0, 1);
      close_out;
   end
endmodule : ewp_top_tb
